/* File: lcp_pkg.sv */
// constants shared by the lcd panel output configuration block
// assumes a single 125 MHz clock and a 32-bit apb register port
package lcp_pkg;
   // ==========================================
   // register map
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_PANEL = 8'h0C;
   localparam logic [7:0] OFS_DISP = 8'h10;
   localparam logic [31:0] PANEL_RST = 32'h0000_0000;
   localparam logic [31:0] DISP_RST = 32'h0000_0000;
   localparam logic [31:0] PANEL_WMASK = 32'h003F_00FB;
   localparam logic [31:0] DISP_WMASK = 32'h03DB_001F;
   // ==========================================
   // field positions, panel type and modulation register
   localparam int MOD_LSB = 16;
   localparam int FMT_BIT = 7;
   localparam int COLOR_BIT = 6;
   localparam int WID_LSB = 4;
   localparam int RES_BIT = 3;
   localparam int TYPE_LSB = 0;
   // ==========================================
   // field positions, display settings register
   localparam int VDBL_BIT = 25;
   localparam int HDBL_BIT = 24;
   localparam int BLANK_BIT = 23;
   localparam int DDIS_BIT = 22;
   localparam int INV_BIT = 20;
   // ==========================================
   // panel types and bus widths
   localparam logic [1:0] PT_PASSIVE = 2'h0;
   localparam logic [1:0] PT_ACTIVE = 2'h1;
   localparam logic [1:0] PT_DIRECT = 2'h2;
   localparam logic [4:0] PW_4 = 5'h04;
   localparam logic [4:0] PW_8 = 5'h08;
   localparam logic [4:0] PW_16 = 5'h10;
   localparam logic [4:0] AW_9 = 5'h09;
   localparam logic [4:0] AW_12 = 5'h0C;
   localparam logic [4:0] AW_18 = 5'h12;
   // ==========================================
   // pixel path
   localparam int PIX_W = 18;
   localparam int FIFO_DEPTH = 8;
   localparam int LINE_MAX = 320;
   localparam logic [17:0] TRUNC_MASK = 18'h3CF3C;
   typedef enum logic {LCP_LIVE, LCP_VREP} lcp_state_t;
endpackage

/* File: lcp_pix_if.sv */
// pixel stream between the fifo and the shaping logic
// assumes both ends share the one clock
interface lcp_pix_if #(parameter int W = 19);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

/* File: lcp_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes the one clock and a synchronous active-low reset
module lcp_fifo #(
   parameter int W = 19,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // streams
   lcp_pix_if.snk in_s,
   lcp_pix_if.src out_s
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q, rd_q;
   logic [AW:0] cnt_q;
   wire push_w = in_s.valid && in_s.ready;
   wire pop_w = out_s.valid && out_s.ready;
   wire [AW:0] cnt_d = cnt_q + (AW+1)'(push_w) - (AW+1)'(pop_w);
   logic room_q;
   // ==========================================
   // flags
   // room is looked ahead one cycle so ready leaves a flop
   assign in_s.ready = room_q;
   assign out_s.valid = cnt_q != '0;
   assign out_s.data = mem[rd_q];
   // ==========================================
   // storage
   always_ff @(posedge clock) begin
      if (push_w) begin
         mem[wr_q] <= in_s.data;
      end
   end
   always_ff @(posedge clock) begin
      if (!resetn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         room_q <= 1'b1;
      end else begin
         if (push_w) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop_w) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_d;
         room_q <= cnt_d != (AW+1)'(DEPTH);
      end
   end
   a_fifo_bound: assert property (@(posedge clock) disable iff (!resetn)
      cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule

/* File: lcp_modgen.sv */
// ac modulation toggle generator for passive panels
// assumes frame and line pulses are one cycle wide
module lcp_modgen #(
   parameter int RATE_W = 6
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // control
   input wire logic enable,
   input wire logic [RATE_W-1:0] rate,
   input wire logic frame_pulse,
   input wire logic line_pulse,
   // output
   output logic toggle_q
);
   logic [RATE_W-1:0] cnt_q;
   wire zero_w = rate == '0;
   wire last_w = cnt_q + 1'b1 >= rate;
   wire flip_w = enable && (zero_w ? frame_pulse : (line_pulse && last_w));
   always_ff @(posedge clock) begin
      if (!resetn) begin
         cnt_q <= '0;
         toggle_q <= 1'b0;
      end else begin
         if (!enable || zero_w) begin
            cnt_q <= '0;
         end else if (line_pulse) begin
            cnt_q <= last_w ? '0 : cnt_q + 1'b1;
         end
         if (!enable) begin
            toggle_q <= 1'b0;
         end else if (flip_w) begin
            toggle_q <= !toggle_q;
         end
      end
   end
   a_mod_frame: assert property (@(posedge clock) disable iff (!resetn)
      enable && zero_w && frame_pulse |=> toggle_q != $past(toggle_q))
      else $error("modulation did not toggle on frame pulse");
   a_mod_line: assert property (@(posedge clock) disable iff (!resetn)
      enable && !zero_w && !line_pulse |=> toggle_q == $past(toggle_q))
      else $error("modulation toggled without a line pulse");
endmodule

/* File: lcp_top.sv */
// lcd panel output configuration: registers, pixel shaping, modulation
// assumes pix_en pulses at the panel pixel rate, data arrive post lookup table
// Operation
// - rate zero toggles modulation once per frame pulse, passive panels only
// - nonzero rate n toggles modulation once every n line pulses, passive panels only
// - format bit picks 8-bit single colour passive format 1 or 2
// - colour bit selects monochrome at 0, colour at 1
// - width code picks 4/8/16 passive or 9/12/18 active bits
// - direct interface resolution bit picks 160x160 or 320x240, else ignored
// - panel type code: passive, active, direct, reserved
// - vertical doubling repeats every source line
// - horizontal doubling repeats every source pixel
// - blank stops the pipeline and forces panel data to zero
// - dithering on gives 64 shades, off limits passive panels to 16 shades
// - invert bit inverts video data to the panel
// - inversion acts after the lookup table stage
module lcp_top
   import lcp_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int LINE_LEN = LINE_MAX
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_q,
   output logic pready_q,
   output logic pslverr_q,
   // pixel source, post lookup table
   input wire logic pix_in_valid,
   input wire logic [PIX_W-1:0] pix_in_data,
   input wire logic pix_in_eol,
   output logic pix_in_ready,
   // panel timing
   input wire logic pix_en,
   input wire logic frame_pulse,
   input wire logic line_pulse,
   // panel outputs
   output logic [PIX_W-1:0] panel_data_q,
   output logic panel_valid_q,
   output logic ac_modulation_output,
   output logic [1:0] panel_type_q,
   output logic color_panel_q,
   output logic passive_format2_q,
   output logic [4:0] bus_width_q,
   output logic res_320x240_q
);
   localparam int LW = $clog2(LINE_LEN);
   // ==========================================
   // register file
   logic [31:0] panel_q, disp_q;
   wire setup_w = psel && !penable;
   wire [7:0] addr_w = 8'(paddr);
   wire sel_stat_w = addr_w == OFS_STATUS;
   wire sel_panel_w = addr_w == OFS_PANEL;
   wire sel_disp_w = addr_w == OFS_DISP;
   wire hit_w = sel_stat_w || sel_panel_w || sel_disp_w;
   wire wr_w = psel && penable && pwrite && pready_q && !pslverr_q;
   lcp_state_t st_q;
   logic [31:0] stat_w;
   logic [31:0] rd_mux_w;
   assign rd_mux_w = sel_panel_w ? panel_q : sel_disp_w ? disp_q : stat_w;
   always_ff @(posedge clock) begin
      if (!resetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= setup_w;
         pslverr_q <= setup_w && !hit_w;
         prdata_q <= (setup_w && !pwrite && hit_w) ? rd_mux_w : 32'h0000_0000;
      end
   end
   always_ff @(posedge clock) begin
      if (!resetn) begin
         panel_q <= PANEL_RST;
         disp_q <= DISP_RST;
      end else if (wr_w && sel_panel_w) begin
         panel_q <= pwdata & PANEL_WMASK;
      end else if (wr_w && sel_disp_w) begin
         disp_q <= pwdata & DISP_WMASK;
      end
   end
   // ==========================================
   // decoded configuration
   wire [1:0] ptype_w = panel_q[TYPE_LSB+:2];
   wire passive_w = ptype_w == PT_PASSIVE;
   wire [1:0] wcode_w = panel_q[WID_LSB+:2];
   wire color_w = panel_q[COLOR_BIT];
   wire [5:0] rate_w = panel_q[MOD_LSB+:6];
   wire vdbl_w = disp_q[VDBL_BIT];
   wire hdbl_w = disp_q[HDBL_BIT];
   wire blank_w = disp_q[BLANK_BIT];
   wire trunc_w = passive_w && disp_q[DDIS_BIT];
   wire inv_w = disp_q[INV_BIT];
   logic [4:0] width_w;
   always_comb begin
      width_w = 5'h00; // reserved codes drive nothing
      if (ptype_w != 2'h3) begin
         case (wcode_w)
            2'h0: width_w = passive_w ? PW_4 : AW_9;
            2'h1: width_w = passive_w ? PW_8 : AW_12;
            2'h2: width_w = passive_w ? PW_16 : AW_18;
            default: width_w = 5'h00;
         endcase
      end
   end
   wire [PIX_W-1:0] wmask_w = (18'h00001 << width_w) - 18'h00001;
   always_ff @(posedge clock) begin
      if (!resetn) begin
         panel_type_q <= 2'h0;
         color_panel_q <= 1'b0;
         passive_format2_q <= 1'b0;
         bus_width_q <= 5'h00;
         res_320x240_q <= 1'b0;
      end else begin
         panel_type_q <= ptype_w;
         color_panel_q <= color_w;
         passive_format2_q <= passive_w && panel_q[FMT_BIT];
         bus_width_q <= width_w;
         res_320x240_q <= (ptype_w == PT_DIRECT) && panel_q[RES_BIT];
      end
   end
   // ==========================================
   // modulation output
   lcp_modgen #(.RATE_W(6)) u_mod (
      .clock(clock),
      .resetn(resetn),
      .enable(passive_w),
      .rate(rate_w),
      .frame_pulse(frame_pulse),
      .line_pulse(line_pulse),
      .toggle_q(ac_modulation_output)
   );
   // ==========================================
   // input buffering
   lcp_pix_if #(.W(PIX_W+1)) in_s ();
   lcp_pix_if #(.W(PIX_W+1)) buf_s ();
   assign in_s.valid = pix_in_valid;
   assign in_s.data = {pix_in_eol, pix_in_data};
   assign pix_in_ready = in_s.ready;
   lcp_fifo #(.W(PIX_W+1), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .resetn(resetn),
      .in_s(in_s),
      .out_s(buf_s)
   );
   // ==========================================
   // pixel sequencing
   logic [PIX_W-1:0] line_mem [LINE_LEN];
   logic [PIX_W-1:0] cur_q;
   logic cur_eol_q, rep_q;
   logic [LW-1:0] wr_q, rd_q, len_q;
   wire step_w = pix_en && !blank_w; // blanking stalls the pipeline
   wire take_w = step_w && !rep_q && st_q == LCP_LIVE && buf_s.valid;
   wire replay_w = step_w && !rep_q && st_q == LCP_VREP;
   wire repeat_w = step_w && rep_q;
   wire rep_eol_w = rd_q == len_q;
   wire in_eol_w = buf_s.data[PIX_W];
   assign buf_s.ready = take_w;
   wire [PIX_W-1:0] raw_w = repeat_w ? cur_q : replay_w ? line_mem[rd_q] : buf_s.data[PIX_W-1:0];
   wire emit_w = take_w || replay_w || repeat_w;
   wire new_eol_w = replay_w ? rep_eol_w : in_eol_w;
   // ==========================================
   // pixel shaping
   wire [PIX_W-1:0] inv_pix_w = inv_w ? ~raw_w : raw_w;
   wire [PIX_W-1:0] mono_w = {3{inv_pix_w[11:6]}};
   wire [PIX_W-1:0] tone_w = color_w ? inv_pix_w : mono_w;
   // dithering keeps six bits per channel, without it four survive on passive panels
   wire [PIX_W-1:0] dith_w = trunc_w ? (tone_w & TRUNC_MASK) : tone_w;
   wire [PIX_W-1:0] shaped_w = dith_w & wmask_w;
   assign stat_w = {29'h0, blank_w, st_q == LCP_VREP, ac_modulation_output};
   always_ff @(posedge clock) begin
      if (take_w && vdbl_w) begin
         line_mem[wr_q] <= buf_s.data[PIX_W-1:0];
      end
   end
   always_ff @(posedge clock) begin
      if (!resetn) begin
         panel_data_q <= '0;
         panel_valid_q <= 1'b0;
      end else if (blank_w) begin
         panel_data_q <= '0;
         panel_valid_q <= 1'b0;
      end else if (pix_en) begin
         panel_data_q <= emit_w ? shaped_w : '0;
         panel_valid_q <= emit_w;
      end
   end
   always_ff @(posedge clock) begin
      if (!resetn) begin
         cur_q <= '0;
         cur_eol_q <= 1'b0;
         rep_q <= 1'b0;
      end else if (take_w || replay_w) begin
         cur_q <= raw_w;
         cur_eol_q <= new_eol_w;
         rep_q <= hdbl_w;
      end else if (repeat_w) begin
         rep_q <= 1'b0;
      end
   end
   // line end opens the replay once the last pixel has gone out
   wire end_live_w = (take_w && in_eol_w && !hdbl_w) || (repeat_w && cur_eol_q);
   wire end_rep_w = (replay_w && rep_eol_w && !hdbl_w) || (repeat_w && cur_eol_q);
   always_ff @(posedge clock) begin
      if (!resetn) begin
         st_q <= LCP_LIVE;
         wr_q <= '0;
         rd_q <= '0;
         len_q <= '0;
      end else begin
         case (st_q)
            LCP_LIVE: begin
               if (take_w && vdbl_w) begin
                  wr_q <= in_eol_w ? '0 : (wr_q == LW'(LINE_LEN-1)) ? wr_q : wr_q + 1'b1;
                  if (in_eol_w) begin
                     len_q <= wr_q;
                  end
               end
               if (end_live_w && vdbl_w) begin
                  st_q <= LCP_VREP;
                  rd_q <= '0;
               end
            end
            LCP_VREP: begin
               if (replay_w && !rep_eol_w) begin
                  rd_q <= rd_q + 1'b1;
               end
               if (end_rep_w) begin
                  st_q <= LCP_LIVE;
               end
            end
            default: st_q <= LCP_LIVE;
         endcase
      end
   end
   // ==========================================
   // checks
   sequence s_fresh;
      take_w && hdbl_w && !blank_w;
   endsequence
   sequence s_second;
      repeat_w ##1 (panel_valid_q && panel_data_q == $past(shaped_w));
   endsequence
   a_hdbl_pending: assert property (@(posedge clock) disable iff (!resetn)
      s_fresh |=> rep_q && !buf_s.ready) else $error("horizontal repeat not pending");
   a_hdbl_copy: assert property (@(posedge clock) disable iff (!resetn)
      repeat_w |-> s_second) else $error("repeated pixel differs");
   a_blank_zero: assert property (@(posedge clock) disable iff (!resetn)
      blank_w |=> panel_data_q == '0 && !panel_valid_q) else $error("blank not zero");
   a_blank_stall: assert property (@(posedge clock) disable iff (!resetn)
      blank_w |-> !buf_s.ready) else $error("pipeline ran while blanked");
   a_invert_data: assert property (@(posedge clock) disable iff (!resetn)
      take_w && inv_w && color_w && !trunc_w && !rep_q
      |=> panel_data_q == (~$past(buf_s.data[PIX_W-1:0]) & $past(wmask_w)))
      else $error("inverted data wrong");
   a_mono_gray: assert property (@(posedge clock) disable iff (!resetn)
      emit_w && !color_w |=> panel_data_q[17:12] == (panel_data_q[11:6] & $past(wmask_w[17:12]))
      && panel_data_q == $past(shaped_w)) else $error("mono channel mismatch");
   a_dith_trunc: assert property (@(posedge clock) disable iff (!resetn)
      emit_w && trunc_w |=> (panel_data_q & ~TRUNC_MASK) == '0)
      else $error("undithered low bits present");
   a_width_mask: assert property (@(posedge clock) disable iff (!resetn)
      ##1 (panel_data_q & ~$past(wmask_w)) == '0) else $error("data beyond bus width");
   a_res_select: assert property (@(posedge clock) disable iff (!resetn)
      ptype_w != PT_DIRECT |=> !res_320x240_q) else $error("resolution bit not ignored");
   a_fmt_pass: assert property (@(posedge clock) disable iff (!resetn)
      passive_w |=> passive_format2_q == $past(panel_q[FMT_BIT]))
      else $error("format select not followed");
   a_vdbl_enter: assert property (@(posedge clock) disable iff (!resetn)
      take_w && in_eol_w && vdbl_w && !hdbl_w |=> st_q == LCP_VREP && rd_q == '0)
      else $error("line replay not started");
endmodule

/* File: lcp_panel_model.sv */
// panel side model: pixel enable, line and frame pulses
// assumes the one clock; every pulse stands still while run is low
module lcp_panel_model #(
   parameter int PIX_DIV = 3,
   parameter int PIX_PER_LINE = 8,
   parameter int LINES_PER_FRAME = 4
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // control from the bench
   input wire logic run,
   // timing to the block
   output logic pix_en = 1'b0,
   output logic line_pulse = 1'b0,
   output logic frame_pulse = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int div_q = 0;
   int pix_q = 0;
   int line_q = 0;
   // ==========================================
   // timing generator
   always @(posedge clock) begin
      pix_en <= 1'b0;
      line_pulse <= 1'b0;
      frame_pulse <= 1'b0;
      if (!resetn) begin
         div_q <= 0;
         pix_q <= 0;
         line_q <= 0;
      end else if (run) begin
         if (div_q == PIX_DIV - 1) begin
            div_q <= 0;
            pix_en <= 1'b1;
            if (pix_q == PIX_PER_LINE - 1) begin
               pix_q <= 0;
               line_pulse <= 1'b1;
               frame_pulse <= (line_q == LINES_PER_FRAME - 1);
               line_q <= (line_q == LINES_PER_FRAME - 1) ? 0 : line_q + 1;
            end else begin
               pix_q <= pix_q + 1;
            end
         end else begin
            div_q <= div_q + 1;
         end
      end
   end
endmodule

/* File: lcd_panel_output_config_tb.sv */
// self-checking bench for the lcd panel output configuration block
// assumes lcp_pkg, the design files and lcp_panel_model are compiled first
module lcd_panel_output_config_tb;
   import lcp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // signals
   logic clock = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata_q, rd, p_cfg = 32'h0, d_cfg = 32'h0;
   logic pready_q, pslverr_q, err, pix_in_ready, pix_en, frame_pulse, line_pulse;
   logic pix_in_valid = 1'b0, pix_in_eol = 1'b0;
   logic [17:0] pix_in_data = 18'h0, panel_data_q;
   logic panel_valid_q, ac_modulation_output, color_panel_q, passive_format2_q, res_320x240_q;
   logic [1:0] panel_type_q;
   logic [4:0] bus_width_q;
   logic run = 1'b0, clr = 1'b0, blank_chk = 1'b0, pen_d = 1'b0, mod_d = 1'b0;
   logic [31:0] seed = 32'h3A4B9A9E;
   logic [17:0] exp_q[$], line_buf[$];
   int n_mismatch = 0, cmp_count = 0, cyc = 0, n_line = 0, n_frame = 0, n_tog = 0;
   // panel cfg, display cfg; doubling only with full-colour uninverted data
   localparam logic [63:0] TBL [10] = '{64'h61_0000_0000, 64'h61_0010_0000,
      64'h11_0000_0000, 64'h60_0040_0000, 64'h50_0000_0000, 64'h42_0000_0000,
      64'h61_0100_0000, 64'h61_0200_0000, 64'h61_0300_0000, 64'h00_0050_0000};

   always #4 clock = ~clock;

   lcp_top #(.LINE_LEN(8)) i_lcp_top (.clock, .resetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata_q, .pready_q, .pslverr_q, .pix_in_valid, .pix_in_data, .pix_in_eol,
      .pix_in_ready, .pix_en, .frame_pulse, .line_pulse, .panel_data_q, .panel_valid_q,
      .ac_modulation_output, .panel_type_q, .color_panel_q, .passive_format2_q,
      .bus_width_q, .res_320x240_q);
   lcp_panel_model i_lcp_panel_model (.clock, .resetn, .run, .pix_en, .line_pulse,
      .frame_pulse);

   // ==========================================
   // expectations
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [4:0] width_of(input logic [31:0] p);
      if (p[5:4] == 2'h3 || p[1:0] == 2'h3) return 5'h00;
      if (p[1:0] == PT_PASSIVE) return p[5:4] == 2'h0 ? PW_4 : p[5:4] == 2'h1 ? PW_8 : PW_16;
      return p[5:4] == 2'h0 ? AW_9 : p[5:4] == 2'h1 ? AW_12 : AW_18;
   endfunction
   function automatic logic [17:0] shape(input logic [17:0] d);
      logic [17:0] r;
      r = d_cfg[INV_BIT] ? ~d : d;
      if (!p_cfg[COLOR_BIT]) r = {3{r[11:6]}};
      if (p_cfg[1:0] == PT_PASSIVE && d_cfg[DDIS_BIT]) r = r & TRUNC_MASK;
      return r & ((18'h1 << width_of(p_cfg)) - 18'h1);
   endfunction

   // ==========================================
   // compare and report
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_pix(input logic [17:0] exp, input logic [17:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected panel pixel: expected %h seen %h", exp, got);
      end
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========================================
   // drivers
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      // no wait limit here: the cycle ceiling ends a hung transfer
      do @(posedge clock); while (pready_q !== 1'b1);
      rd = prdata_q;
      err = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cfg(input logic [31:0] p, input logic [31:0] d);
      apb(1'b1, OFS_PANEL, p);
      apb(1'b1, OFS_DISP, d);
      p_cfg = p;
      d_cfg = d;
      repeat (3) @(posedge clock);
   endtask
   // a fresh edge first, so valid is never lowered and raised in one step
   task automatic put_pix(input logic eol);
      logic [17:0] d;
      seed = lfsr(seed);
      d = seed[17:0];
      @(posedge clock);
      pix_in_valid <= 1'b1;
      pix_in_data <= d;
      pix_in_eol <= eol;
      do @(posedge clock); while (pix_in_ready !== 1'b1);
      pix_in_valid <= 1'b0;
      repeat (d_cfg[HDBL_BIT] ? 2 : 1) exp_q.push_back(shape(d));
      if (d_cfg[VDBL_BIT]) line_buf.push_back(d);
      if (eol && d_cfg[VDBL_BIT]) begin
         foreach (line_buf[i]) repeat (d_cfg[HDBL_BIT] ? 2 : 1) exp_q.push_back(shape(line_buf[i]));
         line_buf.delete();
      end
   endtask
   task automatic drain;
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 3000) begin
         @(posedge clock);
         n++;
      end
      repeat (8) @(posedge clock);
      chk("pixels left", 0, exp_q.size());
   endtask
   task automatic mod_run(input logic [5:0] rate, input logic [1:0] ty, input int lines);
      logic [31:0] e;
      run <= 1'b0;
      cfg(32'h0000_0001, 32'h0);
      cfg({10'h000, rate, 14'h0000, ty}, 32'h0);
      clr <= 1'b1;
      @(posedge clock);
      clr <= 1'b0;
      run <= 1'b1;
      while (n_line < lines) @(posedge clock);
      run <= 1'b0;
      repeat (4) @(posedge clock);
      e = ty != PT_PASSIVE ? 0 : rate == 6'h00 ? n_frame : n_line / rate;
      chk("modulation toggles", e, n_tog);
   endtask

   // ==========================================
   // monitors: pixels against the queue, modulation edges, timeout
   always @(posedge clock) begin
      pen_d <= pix_en;
      mod_d <= ac_modulation_output;
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         print_verdict;
      end
      if (blank_chk) begin
         chk("blanked output", 32'h0, {panel_valid_q, panel_data_q});
      end else if (pen_d && panel_valid_q === 1'b1) begin
         if (exp_q.size() == 0) chk("extra pixel", 32'h0, 32'h1);
         else chk_pix(exp_q.pop_front(), panel_data_q);
      end
      if (clr) begin
         n_line <= 0;
         n_frame <= 0;
         n_tog <= 0;
      end else begin
         n_line <= n_line + int'(line_pulse);
         n_frame <= n_frame + int'(frame_pulse);
         n_tog <= n_tog + int'(mod_d !== ac_modulation_output);
      end
   end

   // ==========================================
   // main sequence
   initial begin
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      apb(1'b0, OFS_PANEL, 32'h0);
      chk("panel reset", PANEL_RST, rd);
      apb(1'b0, OFS_DISP, 32'h0);
      chk("display reset", DISP_RST, rd);
      apb(1'b1, OFS_PANEL, 32'hFFFF_FFFF);
      apb(1'b0, OFS_PANEL, 32'h0);
      chk("panel readback", PANEL_WMASK, rd);
      apb(1'b1, OFS_DISP, 32'hFFFF_FFFF);
      apb(1'b0, OFS_DISP, 32'h0);
      chk("display readback", DISP_WMASK, rd);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped error", 32'h1, err);
      chk("unmapped data", 32'h0, rd);
      for (int t = 0; t < 4; t++) begin
         for (int w = 0; w < 4; w++) begin
            cfg({24'h0, 2'h3, w[1:0], 2'h2, t[1:0]}, 32'h0);
            chk("panel type", t, panel_type_q);
            if (t < 3) chk("bus width", width_of(p_cfg), bus_width_q);
            chk("resolution", t == 2, res_320x240_q);
            chk("format2", t == 0, passive_format2_q);
            chk("colour", 32'h1, color_panel_q);
         end
      end
      cfg(32'h0000_0001, 32'h0);
      chk("mono", 32'h0, color_panel_q);
      run <= 1'b1;
      foreach (TBL[i]) begin
         cfg(TBL[i][63:32], TBL[i][31:0]);
         repeat (5) put_pix(1'b0);
         put_pix(1'b1);
         drain();
      end
      // blank stalls the fifo, so it fills while the panel keeps pulsing
      cfg(32'h0000_0061, 32'h0080_0000);
      blank_chk <= 1'b1;
      repeat (FIFO_DEPTH) put_pix(1'b0);
      repeat (4) @(posedge clock);
      chk("fifo full", 32'h0, pix_in_ready);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("status blank", 32'h4, rd);
      blank_chk <= 1'b0;
      cfg(32'h0000_0061, 32'h0);
      drain();
      chk("fifo empty", 32'h1, pix_in_ready);
      mod_run(6'h00, PT_PASSIVE, 20);
      mod_run(6'h01, PT_PASSIVE, 9);
      mod_run(6'h05, PT_PASSIVE, 23);
      mod_run(6'h3F, PT_PASSIVE, 70);
      mod_run(6'h00, PT_ACTIVE, 12);
      mod_run(6'h03, PT_DIRECT, 12);
      print_verdict;
   end
endmodule
